/* File: rtl/bmf_pkg.sv */
package bmf_pkg;

    // ==========================================================
    // Memory modes
    typedef enum logic [2:0] {
        BMF_SINGLE      = 3'h0,
        BMF_TRUE_DUAL   = 3'h1,
        BMF_PSEUDO_DUAL = 3'h2,
        BMF_ROM         = 3'h3,
        BMF_FIFO        = 3'h4
    } bmf_mode_e;

    // ==========================================================
    // Array geometry
    localparam int unsigned BMF_DATA_BITS   = 8192;
    localparam int unsigned BMF_PARITY_BITS = 9216;
    localparam int unsigned BMF_LANE_BITS   = 9;
    localparam int unsigned BMF_LANES       = 2;
    localparam int unsigned BMF_CS_BITS     = 3;

    // ==========================================================
    // Values after reset
    localparam logic BMF_FULL_RESET  = 1'b0;
    localparam logic BMF_EMPTY_RESET = 1'b1;

endpackage

/* File: rtl/bmf_read_port.sv */
`timescale 1ns/1ps
`default_nettype none

module bmf_read_port #(
    parameter int unsigned WIDTH   = 9,
    parameter bit          REG_OUT = 1'b0
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst_n,
    input  wire logic             i_port_rst,
    input  wire logic             i_capture,
    input  wire logic             i_output_register_gate,
    input  wire logic [WIDTH-1:0] i_data,
    output logic      [WIDTH-1:0] o_data
);

    // ==========================================================
    // Array output stage
    logic [WIDTH-1:0] array_q;
    logic [WIDTH-1:0] array_d;
    logic [WIDTH-1:0] out_q;
    logic [WIDTH-1:0] out_d;

    always_comb begin
        array_d = array_q;
        out_d   = out_q;
        if (i_port_rst) begin
            array_d = '0;
            out_d   = '0;
        end else begin
            if (i_capture) begin
                array_d = i_data;
            end
            if (i_output_register_gate) begin
                out_d = array_q;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            array_q <= '0;
            out_q   <= '0;
        end else begin
            array_q <= array_d;
            out_q   <= out_d;
        end
    end

    // The choice is fixed at build time, so the output is always a flop, never a mux.
    generate
        if (REG_OUT) begin : g_reg
            assign o_data = out_q;
        end else begin : g_direct
            assign o_data = array_q;
        end
    endgenerate

endmodule

`default_nettype wire

/* File: rtl/bmf_block_ram.sv */
`timescale 1ns/1ps
`default_nettype none

module bmf_block_ram #(
    parameter bmf_pkg::bmf_mode_e MODE = bmf_pkg::BMF_TRUE_DUAL,
    parameter int unsigned WIDTH_A     = 9,
    parameter int unsigned WIDTH_B     = 9,
    parameter bit          REG_OUT_A   = 1'b0,
    parameter bit          REG_OUT_B   = 1'b0,
    parameter logic [2:0]  CS_MATCH_A  = 3'h7,
    parameter logic [2:0]  CS_MATCH_B  = 3'h7,
    parameter logic [2:0]  CSW_MATCH   = 3'h3,
    parameter logic [2:0]  CSR_MATCH   = 3'h3,
    parameter int unsigned AF_LEVEL    = 1000,
    parameter int unsigned AE_LEVEL    = 8,
    parameter logic [bmf_pkg::BMF_PARITY_BITS-1:0] INIT_IMAGE = '0,
    localparam int unsigned CAP_A   = (WIDTH_A % bmf_pkg::BMF_LANE_BITS == 0) ?
                                      bmf_pkg::BMF_PARITY_BITS : bmf_pkg::BMF_DATA_BITS,
    localparam int unsigned CAP_B   = (WIDTH_B % bmf_pkg::BMF_LANE_BITS == 0) ?
                                      bmf_pkg::BMF_PARITY_BITS : bmf_pkg::BMF_DATA_BITS,
    localparam int unsigned DEPTH_A = CAP_A / WIDTH_A,
    localparam int unsigned DEPTH_B = CAP_B / WIDTH_B,
    localparam int unsigned AW_A    = $clog2(DEPTH_A),
    localparam int unsigned AW_B    = $clog2(DEPTH_B)
) (
    input  wire logic               i_mclk,
    input  wire logic               i_rst_n,
    input  wire logic               i_a_ce,
    input  wire logic               i_a_output_register_gate,
    input  wire logic               i_a_rst,
    input  wire logic               i_a_we,
    input  wire logic [2:0]         i_a_cs,
    input  wire logic [1:0]         i_a_byte_lane_enable,
    input  wire logic [AW_A-1:0]    i_a_addr,
    input  wire logic [WIDTH_A-1:0] i_a_write_word_in,
    output logic      [WIDTH_A-1:0] o_a_dout,
    input  wire logic               i_b_ce,
    input  wire logic               i_b_output_register_gate,
    input  wire logic               i_b_rst,
    input  wire logic               i_b_we,
    input  wire logic [2:0]         i_b_cs,
    input  wire logic [1:0]         i_b_byte_lane_enable,
    input  wire logic [AW_B-1:0]    i_b_addr,
    input  wire logic [WIDTH_B-1:0] i_b_write_word_in,
    output logic      [WIDTH_B-1:0] o_b_dout,
    input  wire logic [1:0]         i_write_side_select,
    input  wire logic               i_full_status_input,
    input  wire logic [1:0]         i_read_side_select,
    input  wire logic               i_empty_status_input,
    input  wire logic               i_read_output_enable,
    input  wire logic               i_read_pointer_clear,
    output logic                    o_full_flag,
    output logic                    o_almost_full_flag,
    output logic                    o_empty_flag,
    output logic                    o_almost_empty_flag
);

    localparam bit IS_FIFO  = (MODE == bmf_pkg::BMF_FIFO);
    localparam bit A_WRITES = (MODE != bmf_pkg::BMF_ROM);
    localparam bit A_READS  = (MODE != bmf_pkg::BMF_PSEUDO_DUAL) && !IS_FIFO;
    localparam bit B_WRITES = (MODE == bmf_pkg::BMF_TRUE_DUAL);
    localparam bit B_READS  = (MODE == bmf_pkg::BMF_TRUE_DUAL) ||
                              (MODE == bmf_pkg::BMF_PSEUDO_DUAL) || IS_FIFO;
    localparam int unsigned PW = AW_A + 1;

    // ==========================================================
    // Elaboration checks
    generate
        if (!(WIDTH_A inside {1, 2, 4, 9, 18}) || !(WIDTH_B inside {1, 2, 4, 9, 18})) begin : g_bad_w
            $error("Port width must be 1, 2, 4, 9 or 18.");
        end
        if ((WIDTH_A == 18 || WIDTH_B == 18) && !(MODE inside
                {bmf_pkg::BMF_PSEUDO_DUAL, bmf_pkg::BMF_FIFO})) begin : g_bad_18
            $error("Width 18 needs pseudo dual port or FIFO mode.");
        end
        if (IS_FIFO && (WIDTH_A != WIDTH_B || AF_LEVEL > DEPTH_A || AE_LEVEL > DEPTH_A))
        begin : g_bad_fifo
            $error("FIFO needs equal widths and levels within depth.");
        end
    endgenerate

    // ==========================================================
    // Storage array
    // Preloaded from the configuration image; an all-zero image needs no stored copy.
    logic [bmf_pkg::BMF_PARITY_BITS-1:0] mem_q = INIT_IMAGE;

    logic [PW-1:0]      wptr_q;
    logic [PW-1:0]      rptr_q;
    logic [AW_A-1:0]    a_addr;
    logic [AW_B-1:0]    b_addr;
    logic               a_sel;
    logic               b_sel;
    logic               a_wr;
    logic               b_wr;
    logic               a_rd;
    logic               b_rd;
    int                 a_base;
    int                 b_base;
    logic [WIDTH_A-1:0] rdata_a;
    logic [WIDTH_B-1:0] rdata_b;

    // FIFO ports reuse the A (write) and B (read) paths with their own selects.
    assign a_sel = IS_FIFO ? ({i_full_status_input, i_write_side_select} == CSW_MATCH)
                           : (i_a_cs == CS_MATCH_A);
    assign b_sel = IS_FIFO ? ({i_empty_status_input, i_read_side_select} == CSR_MATCH)
                           : (i_b_cs == CS_MATCH_B);
    // The pointer guard stops a miswired flag input from corrupting the queue.
    assign a_wr  = A_WRITES && i_a_ce && a_sel && i_a_we && !(IS_FIFO && o_full_flag);
    assign b_wr  = B_WRITES && i_b_ce && b_sel && i_b_we;
    assign a_rd  = A_READS && i_a_ce && a_sel;
    assign b_rd  = B_READS && i_b_ce && b_sel &&
                   !(IS_FIFO && (!i_read_output_enable || o_empty_flag));
    assign a_addr = IS_FIFO ? wptr_q[AW_A-1:0] : i_a_addr;
    assign b_addr = IS_FIFO ? AW_B'(rptr_q[AW_A-1:0]) : i_b_addr;
    assign a_base = int'(a_addr) * int'(WIDTH_A);
    assign b_base = int'(b_addr) * int'(WIDTH_B);

    generate
        for (genvar i = 0; i < WIDTH_A; i++) begin : g_rd_a
            assign rdata_a[i] = mem_q[a_base + i];
        end
        for (genvar j = 0; j < WIDTH_B; j++) begin : g_rd_b
            assign rdata_b[j] = mem_q[b_base + j];
        end
    endgenerate

    // Array is never reset, so a port reset cannot lose stored data.
    // Both ports writing one bit in a cycle: port A lands last and wins.
    always_ff @(posedge i_mclk) begin
        if (b_wr) begin
            for (int j = 0; j < WIDTH_B; j++) begin
                if (i_b_byte_lane_enable[j / bmf_pkg::BMF_LANE_BITS]) begin
                    mem_q[b_base + j] <= i_b_write_word_in[j];
                end
            end
        end
        if (a_wr) begin
            for (int i = 0; i < WIDTH_A; i++) begin
                if (i_a_byte_lane_enable[i / bmf_pkg::BMF_LANE_BITS]) begin
                    mem_q[a_base + i] <= i_a_write_word_in[i];
                end
            end
        end
    end

    // ==========================================================
    // Read ports
    bmf_read_port #(
        .WIDTH   (WIDTH_A),
        .REG_OUT (REG_OUT_A)
    ) u_port_a (
        .i_mclk                 (i_mclk),
        .i_rst_n                (i_rst_n),
        .i_port_rst             (i_a_rst),
        .i_capture              (a_rd),
        .i_output_register_gate (i_a_output_register_gate),
        .i_data                 (rdata_a),
        .o_data                 (o_a_dout)
    );

    bmf_read_port #(
        .WIDTH   (WIDTH_B),
        .REG_OUT (REG_OUT_B)
    ) u_port_b (
        .i_mclk                 (i_mclk),
        .i_rst_n                (i_rst_n),
        .i_port_rst             (i_b_rst),
        .i_capture              (b_rd),
        .i_output_register_gate (i_b_output_register_gate),
        .i_data                 (rdata_b),
        .o_data                 (o_b_dout)
    );

    // ==========================================================
    // FIFO pointers and flags
    logic [PW-1:0] wptr_d;
    logic [PW-1:0] rptr_d;
    logic [PW-1:0] count_d;
    logic          full_d;
    logic          afull_d;
    logic          empty_d;
    logic          aempty_d;

    always_comb begin
        wptr_d = wptr_q;
        rptr_d = rptr_q;
        if (IS_FIFO && a_wr) begin
            wptr_d = wptr_q + PW'(1);
        end
        if (IS_FIFO && i_read_pointer_clear) begin
            rptr_d = '0;
        end else if (IS_FIFO && b_rd) begin
            rptr_d = rptr_q + PW'(1);
        end
        count_d  = wptr_d - rptr_d;
        full_d   = (count_d == PW'(DEPTH_A));
        afull_d  = (count_d >= PW'(AF_LEVEL));
        empty_d  = (count_d == '0);
        aempty_d = (count_d <= PW'(AE_LEVEL));
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wptr_q              <= '0;
            rptr_q              <= '0;
            o_full_flag         <= bmf_pkg::BMF_FULL_RESET;
            o_almost_full_flag  <= bmf_pkg::BMF_FULL_RESET;
            o_empty_flag        <= bmf_pkg::BMF_EMPTY_RESET;
            o_almost_empty_flag <= bmf_pkg::BMF_EMPTY_RESET;
        end else begin
            wptr_q              <= wptr_d;
            rptr_q              <= rptr_d;
            o_full_flag         <= full_d;
            o_almost_full_flag  <= afull_d;
            o_empty_flag        <= empty_d;
            o_almost_empty_flag <= aempty_d;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    property p_direct_latency;
        (a_rd && !i_a_rst && !REG_OUT_A) |=> (o_a_dout == $past(rdata_a));
    endproperty
    a_direct_latency: assert property (p_direct_latency) else $error("Port A read late.");

    property p_reg_latency;
        (REG_OUT_B && b_rd && !i_b_rst) ##1 (i_b_output_register_gate && !i_b_rst)
            |=> (o_b_dout == $past(rdata_b, 2));
    endproperty
    a_reg_latency: assert property (p_reg_latency) else $error("Port B output stage wrong.");

    property p_port_reset;
        i_a_rst |=> (o_a_dout == '0);
    endproperty
    a_port_reset: assert property (p_port_reset) else $error("Port A reset missed.");

    property p_keep_array;
        (!a_wr && !b_wr) |=> (mem_q == $past(mem_q));
    endproperty
    a_keep_array: assert property (p_keep_array) else $error("Array changed without write.");

    property p_rom_no_write;
        (MODE == bmf_pkg::BMF_ROM) |=> (mem_q == $past(mem_q));
    endproperty
    a_rom_no_write: assert property (p_rom_no_write) else $error("Write in read-only mode.");

    property p_full_blocks;
        (IS_FIFO && ({i_full_status_input, i_write_side_select} != CSW_MATCH)) |-> !a_wr;
    endproperty
    a_full_blocks: assert property (p_full_blocks) else $error("Write past full select.");

    property p_rptr_clear;
        (IS_FIFO && i_read_pointer_clear && !a_wr) |=> (rptr_q == '0) && $stable(wptr_q);
    endproperty
    a_rptr_clear: assert property (p_rptr_clear) else $error("Pointer clear misbehaved.");

    property p_empty_flag;
        IS_FIFO |-> (o_empty_flag == (wptr_q == rptr_q));
    endproperty
    a_empty_flag: assert property (p_empty_flag) else $error("Empty flag wrong.");

    property p_full_flag;
        IS_FIFO |-> (o_full_flag == ((wptr_q - rptr_q) == PW'(DEPTH_A)));
    endproperty
    a_full_flag: assert property (p_full_flag) else $error("Full flag wrong.");

    property p_word_layout;
        (a_wr && !b_wr && (&i_a_byte_lane_enable))
            |=> (mem_q[$past(a_base) +: WIDTH_A] == $past(i_a_write_word_in));
    endproperty
    a_word_layout: assert property (p_word_layout) else $error("Word not stored in place.");

endmodule

`default_nettype wire

/* File: test/bmf_user_logic.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// User core logic on the write side of the queue.
module bmf_user_logic #(
    parameter int unsigned WIDTH = 9
) (
    input  wire logic             i_mclk,
    input  wire logic             i_push,
    output logic                  o_ce,
    output logic                  o_we,
    output logic      [WIDTH-1:0] o_data
);
    initial begin
        o_ce   = 1'h0;
        o_we   = 1'h0;
        o_data = '0;
    end

    // Outside a push the data lines flip, so stale words cannot pass as valid ones.
    always @(posedge i_mclk) begin
        o_ce   <= i_push;
        o_we   <= i_push;
        o_data <= i_push ? WIDTH'($urandom) : ~o_data;
    end
endmodule

`default_nettype wire

/* File: test/test_embedded_block_ram_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module test_embedded_block_ram_fifo;
    // ==========================================================
    // Stimulus and model state.
    logic          i_mclk  = 1'h0;
    logic          i_rst_n = 1'h0;
    logic          ace = 1'h0, awe = 1'h0, bce = 1'h0, gate = 1'h1, arst = 1'h0, brst = 1'h0;
    logic          push = 1'h0, read_output_enable = 1'h0, fbce = 1'h0, clr = 1'h0, fsi = 1'h0, esi = 1'h0;
    logic [2:0]    acs   = 3'h7;
    logic [1:0]    ble   = 2'h3, sel = 2'h3;
    logic [9:0]    aaddr = 10'h0;
    logic [8:0]    awd   = 9'h0, baddr = 9'h0, fexp;
    logic          p_ce, p_we, f_full, f_afull, f_empty, f_aempty;
    logic [8:0]    p_data, f_bout, p_aout, r_aout, last_s = 9'h0, last_r = 9'h0;
    localparam logic [9215:0] ROM_IMG = {512{18'h2d1c3}};
    logic [17:0]   p_bout, last_b = 18'h0;
    logic [9215:0] pm = '0;
    logic [8:0]    fm [1024];
    int            wp = 0, rp = 0, cyc = 0, errors = 0, checks = 0;
    bit            popped = 1'h0, pop_ok, push_ok;

    bmf_block_ram #(
        .MODE      (bmf_pkg::BMF_PSEUDO_DUAL),
        .WIDTH_B   (18),
        .REG_OUT_B (1'h1)
    ) u_bmf_block_ram (
        .i_mclk, .i_rst_n, .i_a_ce(ace), .i_a_output_register_gate(gate), .i_a_rst(arst),
        .i_a_we(awe), .i_a_cs(acs), .i_a_byte_lane_enable(ble), .i_a_addr(aaddr),
        .i_a_write_word_in(awd), .o_a_dout(), .i_b_ce(bce), .i_b_output_register_gate(gate),
        .i_b_rst(brst), .i_b_we(awe), .i_b_cs(acs), .i_b_byte_lane_enable(ble), .i_b_addr(baddr),
        .i_b_write_word_in({awd, awd}), .o_b_dout(p_bout), .i_write_side_select(sel),
        .i_full_status_input(fsi), .i_read_side_select(sel), .i_empty_status_input(esi),
        .i_read_output_enable(read_output_enable), .i_read_pointer_clear(clr), .o_full_flag(),
        .o_almost_full_flag(), .o_empty_flag(), .o_almost_empty_flag()
    );

    bmf_block_ram #(
        .MODE (bmf_pkg::BMF_SINGLE)
    ) u_bmf_block_ram_single (
        .i_mclk, .i_rst_n, .i_a_ce(ace), .i_a_output_register_gate(gate), .i_a_rst(brst),
        .i_a_we(awe), .i_a_cs(acs), .i_a_byte_lane_enable(ble), .i_a_addr(aaddr),
        .i_a_write_word_in(awd), .o_a_dout(p_aout), .i_b_ce(bce),
        .i_b_output_register_gate(gate), .i_b_rst(brst), .i_b_we(awe), .i_b_cs(acs),
        .i_b_byte_lane_enable(ble), .i_b_addr(aaddr), .i_b_write_word_in(awd), .o_b_dout(),
        .i_write_side_select(sel), .i_full_status_input(fsi), .i_read_side_select(sel),
        .i_empty_status_input(esi), .i_read_output_enable(read_output_enable), .i_read_pointer_clear(clr),
        .o_full_flag(), .o_almost_full_flag(), .o_empty_flag(), .o_almost_empty_flag()
    );

    bmf_block_ram #(
        .MODE       (bmf_pkg::BMF_ROM),
        .INIT_IMAGE (ROM_IMG)
    ) u_bmf_block_ram_rom (
        .i_mclk, .i_rst_n, .i_a_ce(ace), .i_a_output_register_gate(gate), .i_a_rst(brst),
        .i_a_we(1'h0),
        .i_a_cs(acs), .i_a_byte_lane_enable(ble), .i_a_addr(aaddr), .i_a_write_word_in(awd),
        .o_a_dout(r_aout), .i_b_ce(1'h0), .i_b_output_register_gate(gate), .i_b_rst(brst),
        .i_b_we(1'h0),
        .i_b_cs(acs), .i_b_byte_lane_enable(ble), .i_b_addr(aaddr), .i_b_write_word_in(awd),
        .o_b_dout(), .i_write_side_select(sel), .i_full_status_input(fsi),
        .i_read_side_select(sel), .i_empty_status_input(esi), .i_read_output_enable(read_output_enable),
        .i_read_pointer_clear(clr), .o_full_flag(), .o_almost_full_flag(), .o_empty_flag(),
        .o_almost_empty_flag()
    );

    bmf_block_ram #(
        .MODE (bmf_pkg::BMF_FIFO)
    ) u_bmf_block_ram_fifo (
        .i_mclk, .i_rst_n, .i_a_ce(p_ce), .i_a_output_register_gate(gate), .i_a_rst(arst),
        .i_a_we(p_we), .i_a_cs(acs), .i_a_byte_lane_enable(ble), .i_a_addr(aaddr),
        .i_a_write_word_in(p_data), .o_a_dout(), .i_b_ce(fbce), .i_b_output_register_gate(gate),
        .i_b_rst(arst), .i_b_we(awe), .i_b_cs(acs), .i_b_byte_lane_enable(ble),
        .i_b_addr({1'h0, baddr}), .i_b_write_word_in(awd), .o_b_dout(f_bout),
        .i_write_side_select(sel), .i_full_status_input(fsi), .i_read_side_select(sel),
        .i_empty_status_input(esi), .i_read_output_enable(read_output_enable), .i_read_pointer_clear(clr),
        .o_full_flag(f_full), .o_almost_full_flag(f_afull), .o_empty_flag(f_empty),
        .o_almost_empty_flag(f_aempty)
    );

    bmf_user_logic u_bmf_user_logic (
        .i_mclk, .i_push(push), .o_ce(p_ce), .o_we(p_we), .o_data(p_data)
    );

    initial begin
        forever #5 i_mclk = ~i_mclk;
    end

    // ==========================================================
    // Reporting.
    task automatic check(input string nm, input logic [17:0] seen, input logic [17:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Port tasks; the caller releases port A so back-to-back writes never double-assign.
    task automatic awrite(input int n, input logic [8:0] d, input logic [2:0] cs, input logic ce);
        ace   = ce;
        awe   = 1'h1;
        acs   = cs;
        aaddr = 10'(n);
        awd   = d;
        if (ce && cs == 3'h7) begin
            last_s = pm[n*9 +: 9];
            last_r = ROM_IMG[n*9 +: 9];
            pm[n*9 +: 9] = d;
        end
        @(negedge i_mclk);
        check("a_dout", p_aout, last_s);
        check("rom_dout", r_aout, last_r);
    endtask

    task automatic bread(input int n);
        logic [17:0] e;
        e     = pm[n*18 +: 18];
        bce   = 1'h1;
        baddr = 9'(n);
        @(negedge i_mclk);
        bce = 1'h0;
        check("b_dout_early", p_bout, last_b);
        @(negedge i_mclk);
        check("b_dout", p_bout, e);
        last_b = e;
    endtask

    task automatic fifo_run(input bit ps, input bit pp, input int n);
        push = ps;
        read_output_enable  = pp;
        fbce = pp;
        repeat (n) @(negedge i_mclk);
    endtask

    // ==========================================================
    // Queue model, updated on the same edge the design takes requests.
    always @(posedge i_mclk) begin
        popped = 1'h0;
        if (i_rst_n) begin
            pop_ok  = fbce && read_output_enable && !esi && wp != rp;
            push_ok = p_ce && p_we && !fsi && wp - rp < 1024;
            if (clr) begin
                rp = 0;
            end else if (pop_ok) begin
                fexp = fm[rp % 1024];
                rp++;
                popped = 1'h1;
            end
            if (push_ok) begin
                fm[wp % 1024] = p_data;
                wp++;
            end
        end
    end

    always @(negedge i_mclk) begin
        if (i_rst_n) begin
            check("full", f_full, wp - rp == 1024);
            check("almost_full", f_afull, wp - rp >= 1000);
            check("empty", f_empty, wp == rp);
            check("almost_empty", f_aempty, wp - rp <= 8);
            if (popped) begin
                check("fifo_dout", f_bout, fexp);
            end
        end
    end

    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 6000) begin
            errors++;
            stop_test();
        end
    end

    // ==========================================================
    // Main sequence.
    initial begin
        int n;
        void'($urandom(32'h35791977));
        repeat (5) @(negedge i_mclk);
        i_rst_n = 1'h1;
        for (int k = 0; k < 8; k++) begin
            n = $urandom_range(511);
            awrite(2 * n, 9'($urandom), 3'h7, 1'h1);
            awrite(2 * n + 1, 9'($urandom), 3'h7, 1'h1);
            awrite(2 * n, 9'($urandom), (k == 3) ? 3'h5 : 3'h7, k != 5);
            ace = 1'h0;
            awe = 1'h0;
            acs = 3'h7;
            bread(n);
        end
        brst = 1'h1;
        @(negedge i_mclk);
        brst = 1'h0;
        check("b_dout_rst", p_bout, 18'h0);
        check("a_dout_rst", p_aout, 9'h0);
        check("rom_dout_rst", r_aout, 9'h0);
        last_b = 18'h0;
        bread(n);
        fifo_run(1'h1, 1'h0, 5);
        fifo_run(1'h0, 1'h1, 3);
        clr = 1'h1;
        fifo_run(1'h0, 1'h1, 1);
        clr = 1'h0;
        fifo_run(1'h0, 1'h1, 8);
        fsi = 1'h1;
        esi = 1'h1;
        fifo_run(1'h1, 1'h1, 4);
        fsi = 1'h0;
        esi = 1'h0;
        fifo_run(1'h1, 1'h0, 1030);
        for (int i = 0; i < 300; i++) begin
            fifo_run(1'($urandom), 1'($urandom), 1);
        end
        fifo_run(1'h0, 1'h1, 1040);
        stop_test();
    end
endmodule

`default_nettype wire
